// file: common/irq_if.sv
/*
  Link between the interrupt sources and the CPU vectoring logic.
  Assumes both ends share mclk; the acknowledge is a one-cycle pulse.
*/
`timescale 1ns/1ps
interface irq_if;
  import irq_src_pkg::*;
  logic tick0_pend;
  logic tick1_pend;
  logic shared_pend;
  logic ack;
  vec_t ack_vec;

  modport src (output tick0_pend, output tick1_pend, output shared_pend, input ack, input ack_vec);
  modport cpu (input tick0_pend, input tick1_pend, input shared_pend, output ack, output ack_vec);
endinterface

// file: common/irq_src_params.svh
/*
  Constants for the tick generators and shared-vector interrupt sources:
  register offsets, field positions, reset values and divider figures.
  Assumes it is included by bare name from the package and design files.
*/
`ifndef IRQ_SRC_PARAMS_SVH
`define IRQ_SRC_PARAMS_SVH

`define ADDR_W              4
`define DATA_W              8

`define OFS_TIME_BASE_CTRL  4'h0
`define OFS_REQ_FLAGS       4'h1
`define OFS_IRQ_ENABLES     4'h2

`define CTRL_RESET          8'h37
`define CTRL_RUN_BIT        7
`define CTRL_CLK_SEL_BIT    6
`define CTRL_LOWPWR_BIT     3

`define FLG_TICK0           0
`define FLG_TICK1           1
`define FLG_SERIAL          2
`define FLG_EXT             3
`define FLG_SSP             4
`define FLG_LV              5
`define FLG_SHARED          6

`define TICK0_MIN_LOG2      8
`define TICK1_MIN_LOG2      12
`define TICK_CNT_W          15
`define SYS_DIV             4

`endif

// file: common/irq_src_pkg.sv
/*
  Types shared by both ends of the interrupt link.
  Assumes the constants header is on the include path.
*/
package irq_src_pkg;
  `include "irq_src_params.svh"

  typedef enum logic [1:0] {
    VEC_TICK0  = 2'b00,
    VEC_TICK1  = 2'b01,
    VEC_SHARED = 2'b11
  } vec_t;

  typedef logic [`DATA_W-1:0] byte_t;
endpackage

// file: rtl/irq_sources.sv
/*
  Interrupt source block: two periodic tick generators, four sources on one
  shared vector, their request flags and enables, and a register port.
  Assumes byte events arrive as one-cycle pulses on mclk, while the peripheral
  pin, the dedicated tick clock and the low-voltage level are asynchronous.
*/
`timescale 1ns/1ps
`include "irq_src_params.svh"

module irq_sources (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic [`ADDR_W-1:0]   reg_addr,
  input  wire irq_src_pkg::byte_t   reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output irq_src_pkg::byte_t        reg_rdata,
  input  wire logic                 tick_dedicated_clock,
  input  wire logic                 serial_module_byte_done,
  input  wire logic                 second_serial_port_byte_done,
  input  wire logic                 ext_periph_irq_pin,
  input  wire logic                 low_voltage_detect,
  output logic                      slow_crystal_low_power,
  irq_if.src                        link
);
  import irq_src_pkg::*;

  // true when the low nbits of a count are all ones, i.e. the next tick wraps
  function automatic logic period_hit(input logic [`TICK_CNT_W-1:0] cnt, input logic [3:0] nbits);
    logic [`TICK_CNT_W-1:0] mask;
    mask = ~({`TICK_CNT_W{1'b1}} << nbits);
    return (cnt & mask) == mask;
  endfunction

  byte_t                  ctrl_r;
  logic [6:0]             flags_r;
  logic [6:0]             flags_nxt;
  logic [6:0]             en_r;
  logic [6:0]             set_ev;
  logic [1:0]             sysdiv_r;
  logic [2:0]             tclk_sync_r;
  logic [2:0]             pin_sync_r;
  logic [1:0]             lv_sync_r;
  logic [`TICK_CNT_W-1:0] tick_cnt_r;
  logic                   tick_in;
  logic                   tick0_ovf;
  logic                   tick1_ovf;
  logic                   wr_ctrl;
  logic                   wr_flags;
  logic                   wr_en;
  logic                   take_tick0;
  logic                   take_tick1;
  logic                   take_shared;
  logic                   shared_src_any;

  assign wr_ctrl  = reg_wr && (reg_addr == `OFS_TIME_BASE_CTRL);
  assign wr_flags = reg_wr && (reg_addr == `OFS_REQ_FLAGS);
  assign wr_en    = reg_wr && (reg_addr == `OFS_IRQ_ENABLES);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      en_r <= 7'h00;
    end else if (wr_en) begin
      en_r <= reg_wdata[6:0];
    end
  end

  assign slow_crystal_low_power = ctrl_r[`CTRL_LOWPWR_BIT];

  // input synchronisers; only the second and later stages feed logic
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tclk_sync_r <= 3'b000;
      pin_sync_r  <= 3'b111;
      lv_sync_r   <= 2'b00;
    end else begin
      tclk_sync_r <= {tclk_sync_r[1:0], tick_dedicated_clock};
      pin_sync_r  <= {pin_sync_r[1:0], ext_periph_irq_pin};
      lv_sync_r   <= {lv_sync_r[0], low_voltage_detect};
    end
  end

  // free-running divide by four of the system clock
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sysdiv_r <= 2'b00;
    end else begin
      sysdiv_r <= sysdiv_r + 2'b01;
    end
  end

  // the dedicated clock is sampled, so it must stay well below mclk/4
  assign tick_in = ctrl_r[`CTRL_CLK_SEL_BIT] ? (sysdiv_r == 2'(`SYS_DIV - 1))
                                             : (tclk_sync_r[1] && !tclk_sync_r[2]);

  // one shared counter: tick0 periods run from 2^8 to 2^15 and tick1 periods from 2^12 to 2^15, all powers of two of the same count
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_r <= '0;
    end else if (!ctrl_r[`CTRL_RUN_BIT]) begin
      tick_cnt_r <= '0;
    end else if (tick_in) begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  assign tick0_ovf = ctrl_r[`CTRL_RUN_BIT] && tick_in
                     && period_hit(tick_cnt_r, 4'(`TICK0_MIN_LOG2) + {1'b0, ctrl_r[2:0]});
  assign tick1_ovf = ctrl_r[`CTRL_RUN_BIT] && tick_in
                     && period_hit(tick_cnt_r, 4'(`TICK1_MIN_LOG2) + {2'b00, ctrl_r[5:4]});

  always_comb begin
    set_ev              = '0;
    set_ev[`FLG_TICK0]  = tick0_ovf;
    set_ev[`FLG_TICK1]  = tick1_ovf;
    set_ev[`FLG_SERIAL] = serial_module_byte_done;
    set_ev[`FLG_EXT]    = pin_sync_r[2] && !pin_sync_r[1];
    set_ev[`FLG_SSP]    = second_serial_port_byte_done;
    set_ev[`FLG_LV]     = lv_sync_r[1];
    set_ev[`FLG_SHARED] = |set_ev[`FLG_LV:`FLG_SERIAL];
  end

  assign take_tick0  = link.ack && (link.ack_vec == VEC_TICK0);
  assign take_tick1  = link.ack && (link.ack_vec == VEC_TICK1);
  assign take_shared = link.ack && (link.ack_vec == VEC_SHARED);

  // a hardware set always beats a software write or a service clear
  always_comb begin
    flags_nxt = flags_r;
    if (wr_flags) begin
      flags_nxt = reg_wdata[6:0];
    end
    if (take_tick0) begin
      flags_nxt[`FLG_TICK0] = 1'b0;
    end
    if (take_tick1) begin
      flags_nxt[`FLG_TICK1] = 1'b0;
    end
    if (take_shared) begin
      flags_nxt[`FLG_SHARED] = 1'b0;
    end
    flags_nxt = flags_nxt | set_ev;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      flags_r <= 7'h00;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign shared_src_any = |(flags_r[`FLG_LV:`FLG_SERIAL] & en_r[`FLG_LV:`FLG_SERIAL]);

  // the global enable and the stack check live in the vectoring end
  assign link.tick0_pend  = flags_r[`FLG_TICK0] && en_r[`FLG_TICK0];
  assign link.tick1_pend  = flags_r[`FLG_TICK1] && en_r[`FLG_TICK1];
  assign link.shared_pend = flags_r[`FLG_SHARED] && en_r[`FLG_SHARED]
                            && shared_src_any;

  // software must route the shared pin to the peripheral input beforehand;
  // otherwise the pin idles high and no falling edge is ever seen

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_TIME_BASE_CTRL: reg_rdata <= ctrl_r;
        `OFS_REQ_FLAGS:      reg_rdata <= {1'b0, flags_r};
        `OFS_IRQ_ENABLES:    reg_rdata <= {1'b0, en_r};
        default:             reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule

// file: rtl/irq_vectoring.sv
/*
  CPU-side vectoring end: global enable, stack-full gating, fixed priority
  and the service acknowledge that clears flags in the source block.
  Assumes the core pulses return-with-enable and reports stack full as a level.
*/
`timescale 1ns/1ps
`include "irq_src_params.svh"

module irq_vectoring (
  input  wire logic          mclk,
  input  wire logic          rst_b,
  input  wire logic          stack_full,
  input  wire logic          global_irq_set,
  input  wire logic          global_irq_clear,
  output logic               global_irq_enable,
  output logic               vector_call,
  output irq_src_pkg::vec_t  vector_id,
  irq_if.cpu                 link
);
  import irq_src_pkg::*;

  logic global_en_r;
  logic any_pend;
  vec_t pick;

  // service is blocked while the stack is full and resumes once it has room
  assign any_pend = link.tick0_pend || link.tick1_pend || link.shared_pend;
  assign link.ack = global_en_r && !stack_full && any_pend;

  always_comb begin
    if (link.tick0_pend) begin
      pick = VEC_TICK0;
    end else if (link.tick1_pend) begin
      pick = VEC_TICK1;
    end else begin
      pick = VEC_SHARED;
    end
  end

  assign link.ack_vec = pick;

  // taking any vector drops the global enable, which wins over a set
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      global_en_r <= 1'b0;
    end else if (link.ack) begin
      global_en_r <= 1'b0;
    end else if (global_irq_set) begin
      global_en_r <= 1'b1;
    end else if (global_irq_clear) begin
      global_en_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      vector_call <= 1'b0;
      vector_id   <= VEC_TICK0;
    end else begin
      vector_call <= link.ack;
      if (link.ack) begin
        vector_id <= pick;
      end
    end
  end

  assign global_irq_enable = global_en_r;
endmodule

// file: testbench/irq_link_sva.sv
/*
  Assertions on the link between the source block and the vectoring end.
  Assumes one clock domain; instantiated once beside the link interface.
*/
`timescale 1ns/1ps
module irq_link_sva (
  input wire logic               mclk,
  input wire logic               rst_b,
  input wire logic               tick0_pend,
  input wire logic               tick1_pend,
  input wire logic               shared_pend,
  input wire logic               ack,
  input wire irq_src_pkg::vec_t  ack_vec
);
  import irq_src_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence taken_s;
    ack ##1 !ack;
  endsequence
  sequence take_vec_s(vec_t v);
    ack && ack_vec == v;
  endsequence

  ack_pulse_a: assert property (ack |-> taken_s)
    else $error("acknowledge held longer than one cycle");
  ack_cause_a: assert property (ack |-> tick0_pend || tick1_pend || shared_pend)
    else $error("acknowledge without a pending request");
  tick0_first_a: assert property (ack && tick0_pend |-> ack_vec == VEC_TICK0)
    else $error("first tick not given the vector");
  tick1_next_a: assert property (ack && !tick0_pend && tick1_pend |-> ack_vec == VEC_TICK1)
    else $error("second tick not given the vector");
  shared_last_a: assert property (ack && !tick0_pend && !tick1_pend |-> ack_vec == VEC_SHARED)
    else $error("shared request not given the vector");
  tick0_clear_a: assert property (take_vec_s(VEC_TICK0) |=> !tick0_pend)
    else $error("first tick still pending after service");
  tick1_clear_a: assert property (take_vec_s(VEC_TICK1) |=> !tick1_pend)
    else $error("second tick still pending after service");
  shared_clear_a: assert property (take_vec_s(VEC_SHARED) |=> !shared_pend)
    else $error("shared request still pending after service");
endmodule

// file: testbench/time_base_and_shared_vector_irq_sources_tb_top.sv
/*
  Testbench joining the source block and the vectoring end over the link.
  Assumes the package, interface and constants header are compiled first.
*/
`timescale 1ns/1ps
`include "irq_src_params.svh"
module time_base_and_shared_vector_irq_sources_tb_top;
  import irq_src_pkg::*;
  logic       mclk = 0, rst_b = 0, rd_s = 0, wr_s = 0, ded_clk = 0, seen;
  // peripheral pin is routed to its interrupt input and idles high
  logic       ser = 0, ssp = 0, ext = 1, lv = 0, sfull = 0, gset_p = 0, gclr = 0;
  logic [3:0] addr = 4'h0;
  byte_t      wdata = 8'h00, rdata;
  logic       lowpwr, gie, vcall;
  vec_t       vid;
  int         fail_count = 0, checks_done = 0, cyc = 0, t0;

  irq_if link ();
  always #10 mclk = ~mclk;
  // dedicated tick clock is exactly 14 mclk periods, so tick intervals are exact
  always #140 ded_clk = ~ded_clk;
  always @(posedge mclk) cyc <= cyc + 1;

  irq_sources u_irq_sources (.mclk(mclk), .rst_b(rst_b), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s),
    .reg_rd(rd_s), .reg_rdata(rdata), .tick_dedicated_clock(ded_clk), .serial_module_byte_done(ser),
    .second_serial_port_byte_done(ssp), .ext_periph_irq_pin(ext), .low_voltage_detect(lv),
    .slow_crystal_low_power(lowpwr), .link(link));
  irq_vectoring u_irq_vectoring (.mclk(mclk), .rst_b(rst_b), .stack_full(sfull), .global_irq_set(gset_p),
    .global_irq_clear(gclr), .global_irq_enable(gie), .vector_call(vcall), .vector_id(vid), .link(link));
  irq_link_sva u_irq_link_sva (.mclk(mclk), .rst_b(rst_b), .tick0_pend(link.tick0_pend),
    .tick1_pend(link.tick1_pend), .shared_pend(link.shared_pend), .ack(link.ack), .ack_vec(link.ack_vec));

  task automatic conclude();
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input byte_t exp, input byte_t got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_n(input string what, input int exp, input int got);
    checks_done++;
    if (got != exp) begin
      fail_count++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input byte_t d);
    @(posedge mclk);
    wr_s  <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr_s  <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input byte_t exp, input string what);
    @(posedge mclk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1;
    chk(what, exp, rdata);
  endtask
  task automatic gset();
    @(posedge mclk);
    gset_p <= 1'b1;
    @(posedge mclk);
    gset_p <= 1'b0;
  endtask
  task automatic gclear();
    @(posedge mclk);
    gclr <= 1'b1;
    @(posedge mclk);
    gclr <= 1'b0;
  endtask
  // a wait that must end in a call counts a mismatch and stops the run on timeout
  task automatic wait_call(input int bound, input bit must);
    seen = 1'b0;
    for (int n = 0; n < bound && !seen; n++) begin
      @(posedge mclk);
      #1;
      seen = (vcall === 1'b1);
    end
    if (must && !seen) begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic tick_run(input byte_t ctrl, input vec_t v, input int period);
    wr(4'h0, ctrl);
    wr(4'h2, (v == VEC_TICK0) ? 8'h01 : 8'h02);
    wr(4'h1, 8'h00);
    gset();
    wait_call(2 * period + 100, 1'b1);
    t0 = cyc;
    chk("tick vector", {6'h00, v}, {6'h00, vid});
    chk("global enable", 8'h00, {7'h00, gie});
    gset();
    wait_call(period + 10, 1'b1);
    chk_n("tick period", period, cyc - t0);
  endtask
  // k: 0 serial module, 1 peripheral pin, 2 second port, 3 low voltage
  task automatic fire(input int k);
    @(posedge mclk);
    case (k)
      0: ser <= 1'b1;
      1: ext <= 1'b0;
      2: ssp <= 1'b1;
      default: lv <= 1'b1;
    endcase
    @(posedge mclk);
    ser <= 1'b0;
    ssp <= 1'b0;
    ext <= 1'b1;
    lv  <= 1'b0;
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rd(4'h0, `CTRL_RESET, "control reset");
    rd(4'h1, 8'h00, "flags reset");
    rd(4'hF, 8'h00, "unmapped read");
    tick_run(8'hC8, VEC_TICK0, 1024);
    chk("low power pin", 8'h01, {7'h00, lowpwr});
    tick_run(8'h80, VEC_TICK0, 3584);
    tick_run(8'hC0, VEC_TICK1, 16384);
    wr(4'h0, 8'h40);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h03);
    gset();
    wait_call(3000, 1'b0);
    chk("stopped ticks", 8'h00, {7'h00, seen});
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      sfull <= 1'b1;
      wr(4'h1, 8'h00);
      wr(4'h2, 8'h40 | (8'h04 << k));
      fire(k);
      repeat (6) @(posedge mclk);
      rd(4'h1, 8'h40 | (8'h04 << k), "raised flags");
      gset();
      wait_call(8, 1'b0);
      chk("call with stack full", 8'h00, {7'h00, seen});
      gclear();
      @(posedge mclk);
      sfull <= 1'b0;
      wait_call(8, 1'b0);
      chk("call with global off", 8'h00, {7'h00, seen});
      wr(4'h2, 8'h40);
      gset();
      wait_call(8, 1'b0);
      chk("call with source off", 8'h00, {7'h00, seen});
      wr(4'h2, 8'h04 << k);
      wait_call(8, 1'b0);
      chk("call with shared off", 8'h00, {7'h00, seen});
      wr(4'h2, 8'h40 | (8'h04 << k));
      wait_call(8, 1'b1);
      chk("shared vector", {6'h00, VEC_SHARED}, {6'h00, vid});
      rd(4'h1, 8'h04 << k, "serviced flags");
    end
    conclude();
  end
endmodule
